// file: hw/rxr_defines.vh
// Register offsets, field layouts, reset values and timing counts of the receive ring controller.
`ifndef RXR_DEFINES_VH
`define RXR_DEFINES_VH
`define RXR_ADDR_W 16
`define RXR_OFF_BASE_LOW 16'h2800
`define RXR_OFF_BASE_HIGH 16'h2804
`define RXR_OFF_LENGTH 16'h2808
`define RXR_OFF_HEAD 16'h2810
`define RXR_OFF_TAIL 16'h2818
`define RXR_OFF_TIMER 16'h2820
`define RXR_OFF_STATUS 16'h2840
`define RXR_OFF_MASK 16'h2844
`define RXR_QUEUE_STRIDE 16'h0100
`define RXR_QUEUE_BIT 8
`define RXR_ALIAS_BASE_LOW 16'h0110
`define RXR_ALIAS_BASE_HIGH 16'h0114
`define RXR_ALIAS_LENGTH 16'h0118
`define RXR_ALIAS_HEAD 16'h0120
`define RXR_ALIAS_TAIL 16'h0128
`define RXR_ALIAS_TIMER 16'h0108
`define RXR_IDX_BASE_LOW 3'h0
`define RXR_IDX_BASE_HIGH 3'h1
`define RXR_IDX_LENGTH 3'h2
`define RXR_IDX_HEAD 3'h3
`define RXR_IDX_TAIL 3'h4
`define RXR_IDX_TIMER 3'h5
`define RXR_IDX_STATUS 3'h6
`define RXR_IDX_MASK 3'h7
`define RXR_BASE_LOW_MASK 32'hFFFFFFF0
`define RXR_LENGTH_MASK 32'h000FFF80
`define RXR_PTR_MASK 32'h0000FFFF
`define RXR_DELAY_MASK 32'h0000FFFF
`define RXR_FLUSH_BIT 31
`define RXR_LEN_LSB 7
`define RXR_LEN_MSB 19
`define RXR_ST_TIMER 0
`define RXR_ST_Q0_DRAINED 1
`define RXR_ST_Q1_DRAINED 2
`define RXR_ST_W 3
`define RXR_RESET_WORD 32'h00000000
`define RXR_RESET_PTR 16'h0000
`define RXR_RESET_ST 3'h0
`define RXR_RESP_OKAY 2'h0
`define RXR_RESP_SLVERR 2'h2
`define RXR_CLK_PS 5000
`define RXR_STEP_PS 1024000
`define RXR_STEP_CYCLES ((`RXR_STEP_PS + `RXR_CLK_PS - 1) / `RXR_CLK_PS)
`endif

// file: hw/rxr_ring_ptr.v
// Ring pointer arithmetic for one receive queue: wrap of the head and free-descriptor test.
`timescale 1ns/1ps
`default_nettype none
`include "rxr_defines.vh"
module rxr_ring_ptr
(
   input wire [15:0] head,
   input wire [15:0] tail,
   input wire [12:0] len_field,
   output wire [15:0] next_head,
   output wire empty
);
   // Descriptors are 16 bytes, so the count is the byte length divided by sixteen.
   function [15:0] wrap_inc;
      input [15:0] ptr;
      input [12:0] len;
      reg [15:0] count;
      reg [16:0] sum;
      begin
         count = {len, 3'h0};
         sum = {1'b0, ptr} + 17'h00001;
         if (sum >= {1'b0, count})
         begin
            wrap_inc = 16'h0000;
         end
         else
         begin
            wrap_inc = sum[15:0];
         end
      end
   endfunction

   assign next_head = wrap_inc(head, len_field);
   assign empty = (head == tail);
endmodule
`default_nettype wire

// file: hw/rxr_pkt_timer.v
// Receive packet delay countdown with forced flush and absolute-timer cancellation.
`timescale 1ns/1ps
`default_nettype none
`include "rxr_defines.vh"
module rxr_pkt_timer
(
   input wire aclk,
   input wire aresetn,
   input wire [15:0] interval,
   input wire pkt_done,
   input wire force_flush,
   input wire abs_expire,
   output reg fire
);
   localparam integer STEP_CYC = `RXR_STEP_CYCLES - 1;
   localparam [7:0] STEP_LAST = STEP_CYC[7:0];
   reg [15:0] count;
   reg [7:0] step;
   reg running;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count <= `RXR_RESET_PTR;
         step <= 8'h00;
         running <= 1'b0;
         fire <= 1'b0;
      end
      else
      begin
         fire <= 1'b0;
         if (force_flush)
         begin
            running <= 1'b0;
            count <= interval;
            step <= 8'h00;
            fire <= 1'b1;
         end
         else if (pkt_done)
         begin
            step <= 8'h00;
            count <= interval;
            if (interval == 16'h0000)
            begin
               running <= 1'b0;
               fire <= 1'b1;
            end
            else
            begin
               running <= 1'b1;
            end
         end
         else if (abs_expire)
         begin
            // Halting here keeps a second interrupt from following the absolute one.
            running <= 1'b0;
            count <= interval;
            step <= 8'h00;
         end
         else if (running)
         begin
            if (step == STEP_LAST)
            begin
               step <= 8'h00;
               if (count == 16'h0001)
               begin
                  running <= 1'b0;
                  count <= interval;
                  fire <= 1'b1;
               end
               else
               begin
                  count <= count - 16'h0001;
               end
            end
            else
            begin
               step <= step + 8'h01;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: hw/rxr_ring_ctrl.v
// Receive descriptor ring control top with AXI4-Lite registers, timer and interrupt.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "rxr_defines.vh"
module rxr_ring_ctrl
(
   input wire aclk,
   input wire aresetn,
   input wire [15:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [15:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire receive_enable_bit,
   input wire desc_consumed0,
   input wire desc_consumed1,
   input wire pkt_done,
   input wire abs_expire,
   output wire [63:0] ring_base0,
   output wire [63:0] ring_base1,
   output wire [19:0] ring_byte_count0,
   output wire [19:0] ring_byte_count1,
   output wire [15:0] ring_head0,
   output wire [15:0] ring_head1,
   output wire [15:0] ring_tail0,
   output wire [15:0] ring_tail1,
   output wire desc_avail0,
   output wire desc_avail1,
   output reg wb_flush,
   output reg rx_timer_cause,
   output wire irq
);
   reg [31:0] base_low [0:1];
   reg [31:0] base_high [0:1];
   reg [31:0] ring_len [0:1];
   reg [15:0] head [0:1];
   reg [15:0] tail [0:1];
   reg [15:0] delay;
   reg [`RXR_ST_W-1:0] status;
   reg [`RXR_ST_W-1:0] mask;
   reg aw_held;
   reg w_held;
   reg [15:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg [`RXR_ST_W-1:0] next_status;
   reg [31:0] rd_value;
   reg rd_hit;
   wire [15:0] next_head0;
   wire [15:0] next_head1;
   wire empty0;
   wire empty1;
   wire timer_fire;
   wire wr_go;
   wire [4:0] wr_dec;
   wire [4:0] rd_dec;
   wire rd_go;
   wire wr_hit;
   wire wr_q;
   wire [2:0] wr_idx;
   wire force_flush;
   wire consume0;
   wire consume1;

   // Decode result is {hit, queue, register index}; aliases fold onto queue zero.
   function [4:0] decode;
      input [15:0] addr;
      reg [15:0] low;
      reg q;
      begin
         low = addr & ~`RXR_QUEUE_STRIDE;
         q = addr[`RXR_QUEUE_BIT];
         decode = 5'h00;
         case (addr)
            `RXR_ALIAS_BASE_LOW: decode = {2'b10, `RXR_IDX_BASE_LOW};
            `RXR_ALIAS_BASE_HIGH: decode = {2'b10, `RXR_IDX_BASE_HIGH};
            `RXR_ALIAS_LENGTH: decode = {2'b10, `RXR_IDX_LENGTH};
            `RXR_ALIAS_HEAD: decode = {2'b10, `RXR_IDX_HEAD};
            `RXR_ALIAS_TAIL: decode = {2'b10, `RXR_IDX_TAIL};
            `RXR_ALIAS_TIMER: decode = {2'b10, `RXR_IDX_TIMER};
            `RXR_OFF_TIMER: decode = {2'b10, `RXR_IDX_TIMER};
            `RXR_OFF_STATUS: decode = {2'b10, `RXR_IDX_STATUS};
            `RXR_OFF_MASK: decode = {2'b10, `RXR_IDX_MASK};
            default:
            begin
               case (low)
                  `RXR_OFF_BASE_LOW: decode = {1'b1, q, `RXR_IDX_BASE_LOW};
                  `RXR_OFF_BASE_HIGH: decode = {1'b1, q, `RXR_IDX_BASE_HIGH};
                  `RXR_OFF_LENGTH: decode = {1'b1, q, `RXR_IDX_LENGTH};
                  `RXR_OFF_HEAD: decode = {1'b1, q, `RXR_IDX_HEAD};
                  `RXR_OFF_TAIL: decode = {1'b1, q, `RXR_IDX_TAIL};
                  default: decode = 5'h00;
               endcase
            end
         endcase
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
         begin
            if (strb[i])
            begin
               merge[i*8 +: 8] = data[i*8 +: 8];
            end
         end
      end
   endfunction

   wire [31:0] head_word = merge({16'h0000, head[wr_q]}, w_data, w_strb);
   wire [31:0] tail_word = merge({16'h0000, tail[wr_q]}, w_data, w_strb);
   wire [31:0] delay_word = merge({16'h0000, delay}, w_data, w_strb);
   wire [31:0] mask_word = merge({29'h0, mask}, w_data, w_strb);
   assign s_axi_awready = ~aw_held;
   assign s_axi_wready = ~w_held;
   assign s_axi_arready = ~s_axi_rvalid;
   assign wr_go = aw_held & w_held & ~s_axi_bvalid;
   assign wr_dec = decode(aw_addr);
   assign wr_hit = wr_dec[4];
   assign wr_q = wr_dec[3];
   assign wr_idx = wr_dec[2:0];
   assign rd_dec = decode(s_axi_araddr);
   assign rd_go = s_axi_arvalid & ~s_axi_rvalid;
   // A zero in the flush bit, or a write that skips its byte lane, starts nothing.
   assign force_flush = wr_go & wr_hit & (wr_idx == `RXR_IDX_TIMER) & w_strb[3]
      & w_data[`RXR_FLUSH_BIT];
   assign consume0 = desc_consumed0 & receive_enable_bit & ~empty0;
   assign consume1 = desc_consumed1 & receive_enable_bit & ~empty1;

   rxr_ring_ptr u_ptr0
   (
      .head(head[0]),
      .tail(tail[0]),
      .len_field(ring_len[0][`RXR_LEN_MSB:`RXR_LEN_LSB]),
      .next_head(next_head0),
      .empty(empty0)
   );

   rxr_ring_ptr u_ptr1
   (
      .head(head[1]),
      .tail(tail[1]),
      .len_field(ring_len[1][`RXR_LEN_MSB:`RXR_LEN_LSB]),
      .next_head(next_head1),
      .empty(empty1)
   );

   rxr_pkt_timer u_timer
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .interval(delay),
      .pkt_done(pkt_done),
      .force_flush(force_flush),
      .abs_expire(abs_expire),
      .fire(timer_fire)
   );

   // Write address and data may arrive in either order; each is held until both are in.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 16'h0000;
         w_data <= `RXR_RESET_WORD;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RXR_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid & ~aw_held)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid & ~w_held)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `RXR_RESP_OKAY : `RXR_RESP_SLVERR;
         end
         else if (s_axi_bvalid & s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register storage; a software write to head beats a same-cycle hardware advance.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         base_low[0] <= `RXR_RESET_WORD;
         base_low[1] <= `RXR_RESET_WORD;
         base_high[0] <= `RXR_RESET_WORD;
         base_high[1] <= `RXR_RESET_WORD;
         ring_len[0] <= `RXR_RESET_WORD;
         ring_len[1] <= `RXR_RESET_WORD;
         head[0] <= `RXR_RESET_PTR;
         head[1] <= `RXR_RESET_PTR;
         tail[0] <= `RXR_RESET_PTR;
         tail[1] <= `RXR_RESET_PTR;
         delay <= `RXR_RESET_PTR;
         mask <= `RXR_RESET_ST;
      end
      else
      begin
         if (consume0)
         begin
            head[0] <= next_head0;
         end
         if (consume1)
         begin
            head[1] <= next_head1;
         end
         if (wr_go & wr_hit)
         begin
            case (wr_idx)
               `RXR_IDX_BASE_LOW:
                  base_low[wr_q] <= merge(base_low[wr_q], w_data, w_strb)
                     & `RXR_BASE_LOW_MASK;
               `RXR_IDX_BASE_HIGH:
                  base_high[wr_q] <= merge(base_high[wr_q], w_data, w_strb);
               `RXR_IDX_LENGTH:
                  ring_len[wr_q] <= merge(ring_len[wr_q], w_data, w_strb)
                     & `RXR_LENGTH_MASK;
               `RXR_IDX_HEAD: head[wr_q] <= head_word[15:0];
               `RXR_IDX_TAIL: tail[wr_q] <= tail_word[15:0];
               `RXR_IDX_TIMER: delay <= delay_word[15:0];
               `RXR_IDX_MASK: mask <= mask_word[`RXR_ST_W-1:0];
               default:
                  mask <= mask;
            endcase
         end
      end
   end

   // Read multiplexer; the flush bit is never stored, so it reads back as zero.
   always @*
   begin
      rd_value = `RXR_RESET_WORD;
      rd_hit = rd_dec[4];
      case (rd_dec[2:0])
         `RXR_IDX_BASE_LOW: rd_value = base_low[rd_dec[3]] & `RXR_BASE_LOW_MASK;
         `RXR_IDX_BASE_HIGH: rd_value = base_high[rd_dec[3]];
         `RXR_IDX_LENGTH: rd_value = ring_len[rd_dec[3]] & `RXR_LENGTH_MASK;
         `RXR_IDX_HEAD: rd_value = {16'h0000, head[rd_dec[3]]};
         `RXR_IDX_TAIL: rd_value = {16'h0000, tail[rd_dec[3]]};
         `RXR_IDX_TIMER: rd_value = {16'h0000, delay};
         `RXR_IDX_STATUS: rd_value = {29'h0, status};
         `RXR_IDX_MASK: rd_value = {29'h0, mask};
         default: rd_value = `RXR_RESET_WORD;
      endcase
      if (!rd_hit)
      begin
         rd_value = `RXR_RESET_WORD;
      end
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `RXR_RESET_WORD;
         s_axi_rresp <= `RXR_RESP_OKAY;
      end
      else
      begin
         if (rd_go)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_hit ? `RXR_RESP_OKAY : `RXR_RESP_SLVERR;
         end
         else if (s_axi_rvalid & s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Reading status clears it, but an event in that same cycle survives the clear.
   always @*
   begin
      next_status = status;
      if (rd_go & rd_hit & (rd_dec[2:0] == `RXR_IDX_STATUS))
      begin
         next_status = `RXR_RESET_ST;
      end
      if (timer_fire)
      begin
         next_status[`RXR_ST_TIMER] = 1'b1;
      end
      if (consume0 & (next_head0 == tail[0]))
      begin
         next_status[`RXR_ST_Q0_DRAINED] = 1'b1;
      end
      if (consume1 & (next_head1 == tail[1]))
      begin
         next_status[`RXR_ST_Q1_DRAINED] = 1'b1;
      end
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         status <= `RXR_RESET_ST;
         wb_flush <= 1'b0;
         rx_timer_cause <= 1'b0;
      end
      else
      begin
         status <= next_status;
         wb_flush <= timer_fire;
         rx_timer_cause <= timer_fire;
      end
   end

   assign irq = |(status & mask);
   assign ring_base0 = {base_high[0], base_low[0]};
   assign ring_base1 = {base_high[1], base_low[1]};
   assign ring_byte_count0 = ring_len[0][19:0];
   assign ring_byte_count1 = ring_len[1][19:0];
   assign ring_head0 = head[0];
   assign ring_head1 = head[1];
   assign ring_tail0 = tail[0];
   assign ring_tail1 = tail[1];
   assign desc_avail0 = ~empty0;
   assign desc_avail1 = ~empty1;
endmodule
`default_nettype wire

// file: sim/rxr_host_ring_model.sv
// Far-side receive model that takes free descriptors and reports delivered packets.
`timescale 1ns/1ps
`default_nettype none
module rxr_host_ring_model
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic rx_req,
   input wire logic eager,
   input wire logic desc_avail0,
   input wire logic [7:0] lat,
   output logic desc_consumed0,
   output logic pkt_done
);
   integer cnt;
   // Eager mode takes a descriptor even from an empty ring, which a real receiver must not do.
   always @(posedge aclk)
   begin
      desc_consumed0 <= 1'b0;
      pkt_done <= 1'b0;
      if (!aresetn)
         cnt <= 0;
      else if (rx_req && (desc_avail0 || eager))
      begin
         desc_consumed0 <= 1'b1;
         cnt <= lat + 1;
      end
      else if (cnt == 1)
      begin
         pkt_done <= 1'b1;
         cnt <= 0;
      end
      else if (cnt > 1)
         cnt <= cnt - 1;
   end
endmodule
`default_nettype wire

// file: sim/rxr_ring_ctrl_assertions.sv
// Concurrent checks on the ports of the receive ring controller.
`timescale 1ns/1ps
`default_nettype none
`include "rxr_defines.vh"
module rxr_ring_ctrl_assertions
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic receive_enable_bit,
   input wire logic desc_consumed0,
   input wire logic [63:0] ring_base0,
   input wire logic [19:0] ring_byte_count0,
   input wire logic [15:0] ring_head0,
   input wire logic [15:0] ring_tail0,
   input wire logic desc_avail0,
   input wire logic wb_flush,
   input wire logic rx_timer_cause
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_force_wr;
      s_axi_awvalid && s_axi_awready && s_axi_awaddr == `RXR_OFF_TIMER && s_axi_wvalid
         && s_axi_wready && s_axi_wdata[31] && s_axi_wstrb[3];
   endsequence
   sequence s_consume;
      desc_consumed0 && receive_enable_bit && !s_axi_awvalid && !s_axi_bvalid;
   endsequence
   a_flush_pair: assert property (wb_flush == rx_timer_cause) else $error("flush and cause differ");
   a_avail_q0: assert property (desc_avail0 == (ring_head0 != ring_tail0)) else $error("avail wrong");
   a_base_align: assert property (ring_base0[3:0] == 4'h0) else $error("base low bits set");
   a_len_low: assert property (ring_byte_count0[6:0] == 7'h00) else $error("length low bits set");
   a_head_cause: assert property ($changed(ring_head0) |-> s_axi_bvalid
      || $past(desc_consumed0 && receive_enable_bit)) else $error("head moved without cause");
   a_head_step: assert property (s_consume and desc_avail0 && ring_byte_count0 != 20'h0
      |=> ring_head0 != $past(ring_head0)) else $error("head did not advance");
   a_empty_hold: assert property (s_consume and !desc_avail0 |=> $stable(ring_head0))
      else $error("head moved on empty ring");
   a_force_flush: assert property (s_force_wr |-> ##[2:4] wb_flush)
      else $error("forced flush missing");
endmodule
bind rxr_ring_ctrl rxr_ring_ctrl_assertions chk_u (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .receive_enable_bit(receive_enable_bit), .desc_consumed0(desc_consumed0),
   .ring_base0(ring_base0), .ring_byte_count0(ring_byte_count0), .ring_head0(ring_head0),
   .ring_tail0(ring_tail0), .desc_avail0(desc_avail0), .wb_flush(wb_flush),
   .rx_timer_cause(rx_timer_cause));
`default_nettype wire

// file: sim/rxr_ring_ctrl_tb_top.sv
// Self-checking bench of the receive ring controller against a behavioural model.
`timescale 1ns/1ps
`default_nettype none
`include "rxr_defines.vh"
module rxr_ring_ctrl_tb_top;
   reg aclk = 1'b0;
   reg aresetn = 1'b0;
   reg [15:0] awaddr = 16'h0000, araddr = 16'h0000;
   reg [31:0] wdata = 32'h0, seed = 32'hA121, got;
   reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   reg en = 0, rx_req = 0, eager = 0, abs_x = 0;
   reg [3:0] strb = 4'hF;
   wire av1;
   reg [7:0] lat = 8'h00;
   reg [1:0] gr;
   reg [31:0] mr [0:65535];
   wire awready, wready, bvalid, arready, rvalid, cons0, pkt_done, wb_flush, cause, irq, av0;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [63:0] base0, base1;
   wire [19:0] cnt0, cnt1;
   wire [15:0] head0, tail0, head1, tail1;
   integer bad_count = 0, n_compared = 0, cyc = 0, tp = 0, tf = 0, tw = 0, nf = 0, nc = 0;
   integer mh, mt, mst, i, q, n0;
   localparam integer T2 = 2 * `RXR_STEP_CYCLES + 2;
   rxr_ring_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .receive_enable_bit(en), .desc_consumed0(cons0),
      .desc_consumed1(1'b0), .pkt_done(pkt_done), .abs_expire(abs_x), .ring_base0(base0),
      .ring_base1(base1), .ring_byte_count0(cnt0), .ring_byte_count1(cnt1), .ring_head0(head0),
      .ring_head1(head1), .ring_tail0(tail0), .ring_tail1(tail1), .desc_avail0(av0),
      .desc_avail1(av1), .wb_flush(wb_flush), .rx_timer_cause(cause), .irq(irq));
   rxr_host_ring_model host_u (.aclk(aclk), .aresetn(aresetn), .rx_req(rx_req), .eager(eager),
      .desc_avail0(av0), .lat(lat), .desc_consumed0(cons0), .pkt_done(pkt_done));
   initial
   begin
      forever #2.5 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      nf <= nf + wb_flush;
      nc <= nc + cause;
      if (pkt_done)
         tp <= cyc;
      if (wb_flush)
         tf <= cyc;
      if (awvalid && awready && wvalid && wready)
         tw <= cyc;
   end
   function [31:0] xs(input integer u);
   begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      xs = seed;
   end
   endfunction
   // Queue 2 stands for the legacy alias block of queue zero.
   function [15:0] adr(input integer qq, input integer k);
      reg [15:0] o;
   begin
      o = (k < 3) ? k * 4 : 16 + (k - 3) * 8;
      adr = (qq == 2) ? 16'h0110 + o : 16'h2800 + qq * 16'h0100 + o;
   end
   endfunction
   function [31:0] msk(input integer k);
   begin
      msk = (k == 0) ? `RXR_BASE_LOW_MASK : (k == 1) ? 32'hFFFFFFFF :
         (k == 2) ? `RXR_LENGTH_MASK : `RXR_PTR_MASK;
   end
   endfunction
   task tally_and_finish;
   begin
      if (bad_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask
   task chk(input [31:0] e, input [31:0] g);
   begin
      n_compared = n_compared + 1;
      if (g !== e)
      begin
         bad_count = bad_count + 1;
         $display("unexpected t=%0t exp=%h got=%h", $time, e, g);
      end
   end
   endtask
   task stall(input integer n);
   begin
      if (n > 60)
      begin
         bad_count = bad_count + 1;
         tally_and_finish;
      end
   end
   endtask
   task wr(input [15:0] a, input [31:0] dd, input [1:0] er);
      integer n;
      reg xa, xw, xb;
   begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= dd;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      xb = 0;
      for (n = 0; !xb; n = n + 1)
      begin
         stall(n);
         @(negedge aclk);
         xa = awvalid && awready;
         xw = wvalid && wready;
         xb = bvalid;
         gr = bresp;
         @(posedge aclk);
         if (xa)
            awvalid <= 1'b0;
         if (xw)
            wvalid <= 1'b0;
      end
      bready <= 1'b0;
      chk(er, gr);
   end
   endtask
   task rd(input [15:0] a, input [31:0] e, input [1:0] er);
      integer n;
      reg xa, xb;
   begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      xb = 0;
      for (n = 0; !xb; n = n + 1)
      begin
         stall(n);
         @(negedge aclk);
         xa = arvalid && arready;
         xb = rvalid;
         got = rdata;
         gr = rresp;
         @(posedge aclk);
         if (xa)
            arvalid <= 1'b0;
      end
      rready <= 1'b0;
      chk(e, got);
      chk(er, gr);
   end
   endtask
   task rx_one(input integer w);
   begin
      @(posedge aclk);
      lat <= xs(0) & 8'h03;
      rx_req <= 1'b1;
      @(posedge aclk);
      rx_req <= 1'b0;
      repeat (w + 8) @(posedge aclk);
   end
   endtask
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (q = 0; q < 2; q = q + 1)
         for (i = 0; i < 5; i = i + 1)
            rd(adr(q, i), 32'h0, `RXR_RESP_OKAY);
      for (q = 0; q < 2; q = q + 1)
         for (i = 0; i < 5; i = i + 1)
         begin
            mr[adr(q, i)] = xs(0) & msk(i);
            wr(adr(q, i), seed, `RXR_RESP_OKAY);
         end
      for (q = 0; q < 3; q = q + 1)
         for (i = 0; i < 5; i = i + 1)
            rd(adr(q, i), mr[adr(q % 2, i)], `RXR_RESP_OKAY);
      chk(mr[16'h2804], base0[63:32]);
      chk(mr[16'h2900], base1[31:0]);
      chk(mr[16'h2908], {12'h000, cnt1});
      chk(mr[16'h2904], base1[63:32]);
      chk(mr[16'h2808], {12'h000, cnt0});
      chk(mr[16'h2910], head1);
      chk(mr[16'h2918], tail1);
      chk(mr[16'h2910] != mr[16'h2918], av1);
      wr(`RXR_ALIAS_TIMER, 32'h7FFF0001, `RXR_RESP_OKAY);
      rd(`RXR_OFF_TIMER, 32'h1, `RXR_RESP_OKAY);
      wr(16'h2920, xs(0), `RXR_RESP_SLVERR);
      rd(16'h2920, 32'h0, `RXR_RESP_SLVERR);
      wr(`RXR_OFF_TIMER, 32'h0, `RXR_RESP_OKAY);
      wr(`RXR_OFF_BASE_LOW, 32'h00001000, `RXR_RESP_OKAY);
      chk(32'h00001000, base0[31:0]);
      wr(`RXR_OFF_LENGTH, 32'h80, `RXR_RESP_OKAY);
      wr(`RXR_OFF_HEAD, 32'h0, `RXR_RESP_OKAY);
      wr(`RXR_OFF_TAIL, 32'h3, `RXR_RESP_OKAY);
      mh = 0;
      mt = 3;
      mst = 0;
      en <= 1'b1;
      eager <= 1'b1;
      // Twelve takes run past the tail three times and wrap the eight-entry ring once.
      for (i = 0; i < 12; i = i + 1)
      begin
         if (i == 5)
         begin
            wr(`RXR_OFF_TAIL, 32'h1, `RXR_RESP_OKAY);
            mt = 1;
         end
         rx_one(0);
         mst = mst | 1;
         if (mh != mt)
         begin
            mh = (mh + 1 >= 8) ? 0 : mh + 1;
            mst = mst | ((mh == mt) ? 2 : 0);
         end
         chk(mh, head0);
         chk(mh != mt, av0);
         chk(2, tf - tp);
      end
      wr(`RXR_OFF_MASK, 32'h2, `RXR_RESP_OKAY);
      chk(1, irq);
      rd(`RXR_OFF_STATUS, mst, `RXR_RESP_OKAY);
      chk(0, irq);
      wr(`RXR_OFF_TIMER, 32'h2, `RXR_RESP_OKAY);
      rx_one(T2);
      chk(T2, tf - tp);
      n0 = nf;
      rx_one(100);
      rx_one(T2);
      chk(n0 + 1, nf);
      chk(T2, tf - tp);
      n0 = nf;
      rx_one(50);
      abs_x <= 1'b1;
      @(posedge aclk);
      abs_x <= 1'b0;
      repeat (T2 + 20) @(posedge aclk);
      chk(n0, nf);
      rx_one(T2);
      chk(T2, tf - tp);
      rd(`RXR_OFF_STATUS, 32'h1, `RXR_RESP_OKAY);
      wr(`RXR_OFF_MASK, 32'h1, `RXR_RESP_OKAY);
      wr(`RXR_OFF_TIMER, 32'h80000002, `RXR_RESP_OKAY);
      repeat (6) @(posedge aclk);
      chk(3, tf - tw);
      chk(1, irq);
      rd(`RXR_OFF_TIMER, 32'h2, `RXR_RESP_OKAY);
      rd(`RXR_OFF_STATUS, 32'h1, `RXR_RESP_OKAY);
      wr(`RXR_OFF_MASK, 32'h0, `RXR_RESP_OKAY);
      n0 = nf;
      wr(`RXR_OFF_TIMER, 32'h80000002, `RXR_RESP_OKAY);
      repeat (6) @(posedge aclk);
      chk(n0 + 1, nf);
      chk(0, irq);
      rd(`RXR_OFF_STATUS, 32'h1, `RXR_RESP_OKAY);
      strb <= 4'h3;
      n0 = nf;
      wr(`RXR_OFF_TIMER, 32'h80000002, `RXR_RESP_OKAY);
      repeat (6) @(posedge aclk);
      chk(n0, nf);
      chk(nf, nc);
      tally_and_finish;
   end
endmodule
`default_nettype wire
